// File: hw/zorb_core.sv
// zero-overhead repeat block control for the fetch pipeline
// Functional notes
// [RULE1] Decode memory-count form: 7-bit size, second word selects count location.
// [RULE2] Decode immediate form: 7-bit size, 16-bit count in second word.
// [RULE3] Repeat count is a 16-bit value from memory or immediate.
// [RULE4] Block runs count plus one times.
// [RULE5] Software keeps blocks at most 127 words.
// [RULE6] Even-aligned block at least 9 words, odd-aligned at least 8.
// [RULE7] Software never nests repeat blocks.
// [RULE8] No call, branch or trap inside a block; interrupts allowed.
// [RULE9] Conditional instructions inside a block execute normally each pass.
// [RULE10] Interrupts masked while loop state is pushed or popped.
// [RULE11] Repeat instruction leaves all seven status flags unchanged.
// [RULE12] Memory form costs four cycles first pass, zero afterwards.
// [RULE13] Immediate form costs one cycle first pass, zero afterwards.
// [RULE14] No alignment cycles or inserted no-ops around the instruction.
// [RULE15] Interrupt entry copies active into shadow, then clears active.
// [RULE16] Interrupt return copies shadow into active and clears shadow.
// [RULE17] Hold end address; clear active after final pass.
// [RULE18] Uninterruptible handler saves loop state only if it loops.
// [RULE19] Interruptible handler pushes before unmasking, masks before popping.
// [RULE20] End label directly follows last instruction of the block.
// [RULE21] Pad 8-word blocks to odd alignment with a preceding no-op.
// [RULE22] At end address with passes left, redirect to start, decrement.
// [RULE23] Reset clears active and shadow bits.
`timescale 1ns/1ps
module zorb_core (
   input  wire logic                       clk_i,
   input  wire logic                       rst_n_i,
   input  wire logic                       en_i,
   input  wire logic                       instr_valid_i,
   input  wire logic [15:0]                instr_lsw_i,
   input  wire logic [15:0]                instr_msw_i,
   input  wire logic [zorb_pkg::PC_W-1:0]  instr_addr_i,
   output logic                            mem_rd_o,
   output logic [zorb_pkg::LOC_W-1:0]      mem_rd_addr_o,
   input  wire logic [15:0]                mem_rd_data_i,
   output logic                            stall_o,
   input  wire logic                       fetch_valid_i,
   input  wire logic [zorb_pkg::PC_W-1:0]  fetch_pc_i,
   output logic                            redirect_o,
   output logic [zorb_pkg::PC_W-1:0]       redirect_pc_o,
   input  wire logic                       int_taken_i,
   input  wire logic                       int_return_i,
   input  wire logic                       rb_wr_i,
   input  wire zorb_pkg::zorb_rb_t         rb_wdata_i,
   output zorb_pkg::zorb_rb_t              rb_o,
   input  wire logic                       flags_wr_i,
   input  wire zorb_pkg::zorb_flags_t      flags_wdata_i,
   output zorb_pkg::zorb_flags_t           flags_o
);
   zorb_pkg::zorb_state_t state_q;
   zorb_pkg::zorb_state_t state_d;
   zorb_pkg::zorb_rb_t    rb_q;
   zorb_pkg::zorb_rb_t    rb_d;
   zorb_pkg::zorb_flags_t flags_q;
   zorb_pkg::zorb_flags_t flags_d;
   logic [zorb_pkg::PC_W-1:0]   start_q;
   logic [zorb_pkg::PC_W-1:0]   start_d;
   logic [zorb_pkg::LOC_W-1:0]  loc_q;
   logic [zorb_pkg::LOC_W-1:0]  loc_d;
   logic [zorb_pkg::SIZE_W-1:0] psize_q;
   logic [zorb_pkg::SIZE_W-1:0] psize_d;
   zorb_pkg::zorb_dec_t         dec;
   logic                        take;
   logic                        at_end;
   logic                        loop_back;
   logic [zorb_pkg::PC_W-1:0]   new_start;

   zorb_decode u_dec (
      .lsw_i   (instr_lsw_i),
      .msw_i   (instr_msw_i),
      .valid_i (instr_valid_i),
      .dec_o   (dec)
   );

   zorb_endmatch u_end (
      .fetch_pc_i    (fetch_pc_i),
      .fetch_valid_i (fetch_valid_i),
      .active_i      (rb_q.active),
      .end_addr_i    (rb_q.end_addr),
      .count_i       (rb_q.count),
      .at_end_o      (at_end),
      .loop_back_o   (loop_back)
   );

   // decoded instruction accepted only when not already loading
   assign take      = en_i && dec.hit && (state_q == zorb_pkg::ZORB_IDLE);
   assign new_start = instr_addr_i + zorb_pkg::INSTR_WORDS;

   // handshake outputs toward fetch and memory
   always_comb begin
      stall_o       = (state_q != zorb_pkg::ZORB_IDLE);           // [RULE12]
      mem_rd_o      = take && !dec.is_imm;                        // [RULE1]
      mem_rd_addr_o = dec.loc;
      // fetch continues through conditional ops; only the address matters
      redirect_o    = en_i && loop_back;                          // [RULE22] [RULE9]
      redirect_pc_o = start_q;
      rb_o          = rb_q;
      flags_o       = flags_q;
   end

   // loading sequence for the memory-count form
   always_comb begin
      state_d = state_q;
      loc_d   = loc_q;
      psize_d = psize_q;
      case (state_q)
         zorb_pkg::ZORB_IDLE: begin
            if (take && !dec.is_imm) begin
               state_d = zorb_pkg::ZORB_MEM1;                     // [RULE12]
               loc_d   = dec.loc;
               psize_d = dec.size;
            end
         end
         zorb_pkg::ZORB_MEM1: state_d = zorb_pkg::ZORB_MEM2;
         zorb_pkg::ZORB_MEM2: state_d = zorb_pkg::ZORB_MEM3;
         zorb_pkg::ZORB_MEM3: state_d = zorb_pkg::ZORB_IDLE;
         default:             state_d = zorb_pkg::ZORB_IDLE;
      endcase
   end

   // loop state register next value
   always_comb begin
      rb_d    = rb_q;
      start_d = start_q;
      if (take) begin
         start_d        = new_start;
         rb_d.size      = dec.size;
         // end holds the last word of the block
         rb_d.end_addr  = new_start +
                          {{(zorb_pkg::PC_W-zorb_pkg::SIZE_W){1'b0}},
                           dec.size} - zorb_pkg::ONE_WORD;        // [RULE17]
         if (dec.is_imm) begin
            rb_d.count  = dec.imm_count;                          // [RULE3]
            rb_d.active = 1'b1;                                   // [RULE13] [RULE14]
         end
      end else if (state_q == zorb_pkg::ZORB_MEM3) begin
         rb_d.count  = mem_rd_data_i;                             // [RULE3]
         rb_d.active = 1'b1;
      end else if (loop_back) begin
         rb_d.count  = rb_q.count - zorb_pkg::CNT_ONE;            // [RULE22] [RULE4]
      end else if (at_end) begin
         rb_d.active = 1'b0;                                      // [RULE17] [RULE4]
      end
      if (rb_wr_i) begin
         rb_d = rb_wdata_i;
      end
      if (int_taken_i) begin
         rb_d.shadow = rb_q.active;                               // [RULE15]
         rb_d.active = 1'b0;
      end else if (int_return_i) begin
         rb_d.active = rb_q.shadow;                               // [RULE16]
         rb_d.shadow = 1'b0;
      end
   end

   // status flags are written by other units only
   always_comb begin
      flags_d = flags_q;
      if (flags_wr_i) begin
         flags_d = flags_wdata_i;                                 // [RULE11]
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= zorb_pkg::ZORB_IDLE;
         rb_q    <= '0;                                           // [RULE23]
         flags_q <= '0;
         start_q <= zorb_pkg::PC_ZERO;
         loc_q   <= '0;
         psize_q <= zorb_pkg::SIZE_ZERO;
      end else if (en_i) begin
         state_q <= state_d;
         rb_q    <= rb_d;
         flags_q <= flags_d;
         start_q <= start_d;
         loc_q   <= loc_d;
         psize_q <= psize_d;
      end
   end

   // checks
   a_mem_stall_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (take && !dec.is_imm) |=> stall_o [*3] ##1 !stall_o) // [RULE12]
      else $error("memory form stall not three cycles");
   a_imm_no_stall: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (take && dec.is_imm) |=> !stall_o) // [RULE13]
      else $error("immediate form stalled");
   a_imm_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (take && dec.is_imm && !rb_wr_i && !int_taken_i && !int_return_i)
      |=> rb_q.active && rb_q.count == $past(instr_msw_i)) // [RULE2]
      else $error("immediate count not loaded");
   a_mem_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (en_i && state_q == zorb_pkg::ZORB_MEM3 && !rb_wr_i && !int_taken_i
       && !int_return_i)
      |=> rb_q.count == $past(mem_rd_data_i) && rb_q.active) // [RULE3]
      else $error("memory count not loaded");
   a_loop_dec: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (redirect_o && !take && !rb_wr_i)
      |=> rb_q.count == $past(rb_q.count) - zorb_pkg::CNT_ONE) // [RULE22]
      else $error("count not decremented on loop back");
   a_last_pass: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (en_i && at_end && rb_q.count == zorb_pkg::CNT_ZERO && !take
       && !rb_wr_i && !int_return_i) |=> !rb_q.active) // [RULE17]
      else $error("active not cleared after final pass");
   a_int_entry: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (en_i && int_taken_i) |=> !rb_q.active
      && rb_q.shadow == $past(rb_q.active)) // [RULE15]
      else $error("interrupt entry did not save active");
   a_int_exit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (en_i && int_return_i && !int_taken_i) |=> !rb_q.shadow
      && rb_q.active == $past(rb_q.shadow)) // [RULE16]
      else $error("interrupt return did not restore active");
   a_flags_kept: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (take && !flags_wr_i) |=> $stable(flags_o)) // [RULE11]
      else $error("repeat instruction changed flags");
   a_redir_target: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      redirect_o |-> redirect_pc_o == start_q && rb_q.active) // [RULE22]
      else $error("redirect without active loop");

   c_imm_start: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      take && dec.is_imm);
   c_mem_start: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      take && !dec.is_imm);
   c_loop_back: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      redirect_o ##[1:200] redirect_o);
   c_int_in_loop: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      rb_q.active && int_taken_i);
endmodule

// File: hw/zorb_pkg.sv
// constants and types for the zero-overhead repeat block
package zorb_pkg;
   localparam int unsigned PC_W       = 22;
   localparam int unsigned SIZE_W     = 7;
   localparam int unsigned CNT_W      = 16;
   localparam int unsigned LOC_W      = 8;
   localparam logic [7:0]  OPC_HI     = 8'hb5;
   localparam logic [7:0]  MSW_MEM_HI = 8'h00;
   localparam int unsigned FORM_BIT   = 7;
   // words of the repeat instruction itself
   localparam logic [PC_W-1:0] INSTR_WORDS = 22'h000002;
   localparam logic [PC_W-1:0] ONE_WORD    = 22'h000001;
   localparam logic [CNT_W-1:0] CNT_ONE    = 16'h0001;
   localparam logic [CNT_W-1:0] CNT_ZERO   = 16'h0000;
   localparam logic [SIZE_W-1:0] SIZE_ZERO = 7'h00;
   localparam logic [PC_W-1:0] PC_ZERO     = 22'h000000;

   typedef enum logic [1:0] {
      ZORB_IDLE = 2'b00,
      ZORB_MEM1 = 2'b01,
      ZORB_MEM2 = 2'b10,
      ZORB_MEM3 = 2'b11
   } zorb_state_t;

   // loop state register image
   typedef struct packed {
      logic              active;
      logic              shadow;
      logic [SIZE_W-1:0] size;
      logic [PC_W-1:0]   end_addr;
      logic [CNT_W-1:0]  count;
   } zorb_rb_t;

   // status flags: test, integer and floating-point zero/negative, latched under/overflow
   typedef struct packed {
      logic test;
      logic int_zero;
      logic int_neg;
      logic flt_zero;
      logic flt_neg;
      logic lat_under;
      logic lat_over;
   } zorb_flags_t;

   typedef struct packed {
      logic              hit;
      logic              is_imm;
      logic [SIZE_W-1:0] size;
      logic [CNT_W-1:0]  imm_count;
      logic [LOC_W-1:0]  loc;
   } zorb_dec_t;
endpackage

// File: hw/zorb_decode.sv
// decoder for both forms of the repeat instruction
`timescale 1ns/1ps
module zorb_decode (
   input  wire logic [15:0]       lsw_i,
   input  wire logic [15:0]       msw_i,
   input  wire logic              valid_i,
   output zorb_pkg::zorb_dec_t    dec_o
);
   logic opc_ok;
   logic imm;

   always_comb begin
      opc_ok = (lsw_i[15:8] == zorb_pkg::OPC_HI);
      imm    = lsw_i[zorb_pkg::FORM_BIT];
      dec_o.is_imm    = imm;
      dec_o.size      = lsw_i[zorb_pkg::SIZE_W-1:0];
      dec_o.imm_count = msw_i;                            // [RULE2]
      dec_o.loc       = msw_i[zorb_pkg::LOC_W-1:0];       // [RULE1]
      // memory form needs zero upper byte in second word
      dec_o.hit = valid_i && opc_ok &&
                  (imm || (msw_i[15:8] == zorb_pkg::MSW_MEM_HI));
   end
endmodule

// File: hw/zorb_endmatch.sv
// end-of-block detection for the fetch stream
`timescale 1ns/1ps
module zorb_endmatch (
   input  wire logic [zorb_pkg::PC_W-1:0]  fetch_pc_i,
   input  wire logic                       fetch_valid_i,
   input  wire logic                       active_i,
   input  wire logic [zorb_pkg::PC_W-1:0]  end_addr_i,
   input  wire logic [zorb_pkg::CNT_W-1:0] count_i,
   output logic                            at_end_o,
   output logic                            loop_back_o
);
   always_comb begin
      at_end_o    = active_i && fetch_valid_i && (fetch_pc_i == end_addr_i);
      loop_back_o = at_end_o && (count_i != zorb_pkg::CNT_ZERO);
   end
endmodule

// File: bench/zorb_fetch_model.sv
// fetch stream and count memory model for the repeat block bench
`timescale 1ns/1ps
module zorb_fetch_model (
   input  wire logic                       clk_i,
   input  wire logic                       rst_n_i,
   input  wire logic                       go_i,
   input  wire logic [zorb_pkg::PC_W-1:0]  start_pc_i,
   input  wire logic                       stall_i,
   input  wire logic                       redirect_i,
   input  wire logic [zorb_pkg::PC_W-1:0]  redirect_pc_i,
   output logic                            fetch_valid_o,
   output logic [zorb_pkg::PC_W-1:0]       fetch_pc_o,
   input  wire logic                       mem_rd_i,
   input  wire logic [zorb_pkg::LOC_W-1:0] mem_rd_addr_i,
   output logic [15:0]                     mem_rd_data_o
);
   logic [zorb_pkg::LOC_W-1:0] loc_q;
   logic                       tog_q;
   assign fetch_valid_o = go_i;
   // count word equals its location; garbage outside the stall window
   assign mem_rd_data_o = stall_i ? {8'h00, loc_q} : {16{tog_q}};
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         loc_q <= '0;
         tog_q <= 1'b0;
         fetch_pc_o <= '0;
      end else begin
         tog_q <= ~tog_q;
         if (mem_rd_i) begin
            loc_q <= mem_rd_addr_i;
         end
         if (!go_i) begin
            fetch_pc_o <= start_pc_i;
         end else if (redirect_i) begin
            fetch_pc_o <= redirect_pc_i;
         end else if (!stall_i) begin
            fetch_pc_o <= fetch_pc_o + 22'h1;
         end
      end
   end
endmodule

// File: bench/zorb_tb_top.sv
// self-checking bench for the repeat block control
`timescale 1ns/1ps
module zero_overhead_repeat_block_tb_top;
   logic                       clk_i, rst_n_i, en_i, instr_valid_i, go;
   logic [15:0]                instr_lsw_i, instr_msw_i, mem_rd_data_i;
   logic [zorb_pkg::PC_W-1:0]  instr_addr_i, start_pc, fetch_pc_i;
   logic [zorb_pkg::PC_W-1:0]  redirect_pc_o;
   logic                       mem_rd_o, stall_o, fetch_valid_i, redirect_o;
   logic                       int_taken_i, int_return_i, rb_wr_i, flags_wr_i;
   logic [zorb_pkg::LOC_W-1:0] mem_rd_addr_o;
   zorb_pkg::zorb_rb_t         rb_wdata_i, rb_o, saved;
   zorb_pkg::zorb_flags_t      flags_wdata_i, flags_o;
   int                         bad_count, tests_run, cycles;

   zorb_core uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en_i),
      .instr_valid_i(instr_valid_i), .instr_lsw_i(instr_lsw_i),
      .instr_msw_i(instr_msw_i), .instr_addr_i(instr_addr_i),
      .mem_rd_o(mem_rd_o), .mem_rd_addr_o(mem_rd_addr_o),
      .mem_rd_data_i(mem_rd_data_i), .stall_o(stall_o),
      .fetch_valid_i(fetch_valid_i), .fetch_pc_i(fetch_pc_i),
      .redirect_o(redirect_o), .redirect_pc_o(redirect_pc_o),
      .int_taken_i(int_taken_i), .int_return_i(int_return_i),
      .rb_wr_i(rb_wr_i), .rb_wdata_i(rb_wdata_i), .rb_o(rb_o),
      .flags_wr_i(flags_wr_i), .flags_wdata_i(flags_wdata_i),
      .flags_o(flags_o));
   zorb_fetch_model far (.clk_i(clk_i), .rst_n_i(rst_n_i), .go_i(go),
      .start_pc_i(start_pc), .stall_i(stall_o), .redirect_i(redirect_o),
      .redirect_pc_i(redirect_pc_o), .fetch_valid_o(fetch_valid_i),
      .fetch_pc_o(fetch_pc_i), .mem_rd_i(mem_rd_o),
      .mem_rd_addr_i(mem_rd_addr_o), .mem_rd_data_o(mem_rd_data_i));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task check(input string what, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task end_of_test;
      $display("mismatches %0d checks %0d", bad_count, tests_run);
      if (bad_count == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // one-cycle strobe: 0 flags write, 1 entry, 2 return, 3 state load
   task pulse(input int which);
      @(posedge clk_i);
      case (which)
         0: flags_wr_i <= 1'b1;
         1: int_taken_i <= 1'b1;
         2: int_return_i <= 1'b1;
         default: rb_wr_i <= 1'b1;
      endcase
      @(posedge clk_i);
      {flags_wr_i, int_taken_i, int_return_i, rb_wr_i} <= 4'h0;
      @(negedge clk_i);
   endtask

   task take(input logic [15:0] lsw, msw,
             input logic [zorb_pkg::PC_W-1:0] addr, input int stalls);
      int i;
      @(posedge clk_i);
      instr_valid_i <= 1'b1;
      instr_lsw_i <= lsw;
      instr_msw_i <= msw;
      instr_addr_i <= addr;
      start_pc <= addr + 22'h2;
      @(negedge clk_i);
      check("mem_rd_o", 32'(mem_rd_o), 32'(stalls != 0));
      if (stalls != 0) begin
         check("mem_rd_addr_o", 32'(mem_rd_addr_o), 32'(msw[7:0]));
      end
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      for (i = 0; i < 4; i++) begin
         @(negedge clk_i);
         check("stall_o", 32'(stall_o), 32'(i < stalls));
      end
      check("active", 32'(rb_o.active), 32'h1);
      check("size", 32'(rb_o.size), 32'(lsw[6:0]));
      check("count", 32'(rb_o.count),
            stalls != 0 ? 32'(msw[7:0]) : 32'(msw));
      check("end_addr", 32'(rb_o.end_addr),
            32'(addr + 22'(lsw[6:0]) + 22'h1));
   endtask

   task run_loop(input int exp);
      int i;
      int n;
      n = 0;
      @(posedge clk_i);
      go <= 1'b1;
      for (i = 0; i < 400; i++) begin
         @(negedge clk_i);
         if (redirect_o === 1'b1) begin
            n++;
            check("redirect_pc_o", 32'(redirect_pc_o), 32'(start_pc));
         end
         if (rb_o.active !== 1'b1) begin
            break;
         end
      end
      @(posedge clk_i);
      go <= 1'b0;
      check("loop backs", 32'(n), 32'(exp));
      check("active after", 32'(rb_o.active), 32'h0);
   endtask

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         end_of_test;
      end
   end

   initial begin
      {rst_n_i, instr_valid_i, go, int_taken_i, int_return_i} = '0;
      {rb_wr_i, flags_wr_i, instr_lsw_i, instr_msw_i} = '0;
      {instr_addr_i, start_pc, rb_wdata_i, flags_wdata_i} = '0;
      en_i = 1'b1;
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(negedge clk_i);
      check("reset active", 32'(rb_o.active), 32'h0);
      check("reset shadow", 32'(rb_o.shadow), 32'h0);
      @(posedge clk_i);
      flags_wdata_i <= 7'h55;
      pulse(0);
      // odd-aligned 8 words, 127 words, even-aligned 9 words from memory
      take(16'hb588, 16'h0002, 22'h000101, 0);
      run_loop(2);
      take(16'hb5ff, 16'h0000, 22'h000300, 0);
      run_loop(0);
      take(16'hb509, 16'h0003, 22'h000200, 3);
      run_loop(3);
      take(16'hb588, 16'h0005, 22'h000101, 0);
      @(posedge clk_i);
      go <= 1'b1;
      repeat (3) @(posedge clk_i);
      go <= 1'b0;
      pulse(1);
      check("irq active", 32'(rb_o.active), 32'h0);
      check("irq shadow", 32'(rb_o.shadow), 32'h1);
      check("irq count", 32'(rb_o.count), 32'h5);
      // handler with masked interrupts saves and restores loop state
      saved = rb_o;
      @(posedge clk_i);
      rb_wdata_i <= saved;
      pulse(3);
      check("popped count", 32'(rb_o.count), 32'(saved.count));
      pulse(2);
      check("ret active", 32'(rb_o.active), 32'h1);
      check("ret shadow", 32'(rb_o.shadow), 32'h0);
      run_loop(5);
      check("flags", 32'(flags_o), 32'h55);
      end_of_test;
   end
endmodule
